/* File: core/timer8_pkg.sv */
package timer8_pkg;

    //------------------------------------------------------------
    // Register map
    //------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_CMP_A = 8'h08;
    localparam logic [7:0] OFS_CMP_B = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_FORCE = 8'h14;

    //------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------
    localparam int MODE_LSB  = 0;
    localparam int ACT_A_LSB = 4;
    localparam int ACT_B_LSB = 6;
    localparam int FLAG_OVF  = 0;
    localparam int FLAG_MA   = 1;
    localparam int FLAG_MB   = 2;

    //------------------------------------------------------------
    // Reset values and count limits
    //------------------------------------------------------------
    localparam logic [2:0] MODE_RST     = 3'h0;
    localparam logic [1:0] ACT_RST      = 2'h0;
    localparam logic [7:0] COUNT_RST    = 8'h00;
    localparam logic [7:0] CMP_RST      = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    //------------------------------------------------------------
    // Wave mode and output action codes
    //------------------------------------------------------------
    localparam logic [2:0] MODE_PC_FF   = 3'h1;
    localparam logic [2:0] MODE_CTC     = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_PC_A    = 3'h5;
    localparam logic [2:0] MODE_FAST_A  = 3'h7;
    localparam logic [1:0] ACT_OFF      = 2'h0;
    localparam logic [1:0] ACT_TOGGLE   = 2'h1;
    localparam logic [1:0] ACT_CLEAR    = 2'h2;

    // Decoded counting kind, one-hot
    typedef enum logic [3:0] {
        K_NORMAL = 4'h1,
        K_CTC    = 4'h2,
        K_FAST   = 4'h4,
        K_PHASE  = 4'h8
    } kind_t;

endpackage

/* File: core/timer8_waveform_modes.sv */
`timescale 1ns/10ps
module timer8_waveform_modes
    import timer8_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // Timer clock enable from the prescaler
    input  wire logic        TIMER_TICK,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Waveform pins
    output logic             WAVE_OUT_A,
    output logic             WAVE_OUT_A_EN,
    output logic             WAVE_OUT_B,
    output logic             WAVE_OUT_B_EN,
    // Event flags
    output logic             OVERFLOW_FLAG,
    output logic             MATCH_A_FLAG,
    output logic             MATCH_B_FLAG
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    logic [2:0]  wave_mode_sel;
    logic [1:0]  out_action_sel [2];
    logic [7:0]  count_value;
    logic        count_up;
    logic        block_match;
    logic [7:0]  compare_buf    [2];
    logic [7:0]  compare_value  [2];
    logic        wave_out       [2];
    logic        wave_en        [2];
    logic        match_flag     [2];
    logic        pending_up     [2];
    logic        match          [2];
    logic        overflow_flag;
    kind_t       kind;
    logic [7:0]  top;
    logic        at_top;
    logic        at_bottom;
    logic        pwm;
    logic        up_eff;
    logic        done;
    logic        wr;
    logic        count_wr;
    logic        force_wr;
    logic        flags_wr;
    logic        tick;
    logic        load;
    logic        ovf_event;
    logic        mapped;
    logic [31:0] next_rdata;

    //------------------------------------------------------------
    // Mode decode
    //------------------------------------------------------------
    // Counting depends on wave mode only, never on actions
    always_comb begin
        case (wave_mode_sel)
            MODE_CTC:                 kind = K_CTC;
            MODE_FAST_FF, MODE_FAST_A: kind = K_FAST;
            MODE_PC_FF, MODE_PC_A:    kind = K_PHASE;
            default:                  kind = K_NORMAL;
        endcase
    end

    // Top is compare A in mode 2 and in PWM modes with bit2 set
    always_comb begin
        if (kind == K_CTC || (wave_mode_sel[2] && kind != K_NORMAL)) begin
            top = compare_value[0];
        end else begin
            top = COUNT_MAX;
        end
    end

    assign at_top    = (count_value == top);
    assign at_bottom = (count_value == COUNT_BOTTOM);
    assign pwm       = (kind == K_FAST) || (kind == K_PHASE);
    // Direction seen by a match: turning points count as their slope
    assign up_eff    = at_bottom ? 1'b1 : (at_top ? 1'b0 : count_up);

    //------------------------------------------------------------
    // APB decode
    //------------------------------------------------------------
    // One wait state; writes land at the edge with PREADY high
    assign done     = PSEL && PENABLE && PREADY;
    assign wr       = done && PWRITE;
    assign count_wr = wr && (PADDR == OFS_COUNT);
    assign force_wr = wr && (PADDR == OFS_FORCE);
    assign flags_wr = wr && (PADDR == OFS_FLAGS);
    // A count write overrides the tick in the same cycle
    assign tick     = TIMER_TICK && !count_wr;
    // Unmapped offsets answer with an error; writes are dropped
    assign mapped   = (PADDR == OFS_CTRL) || (PADDR == OFS_COUNT) ||
                      (PADDR == OFS_CMP_A) || (PADDR == OFS_CMP_B) ||
                      (PADDR == OFS_FLAGS) || (PADDR == OFS_FORCE);

    //------------------------------------------------------------
    // Control register
    //------------------------------------------------------------
    // Actions are unbuffered and act from the next match on
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            wave_mode_sel     <= MODE_RST;
            out_action_sel[0] <= ACT_RST;
            out_action_sel[1] <= ACT_RST;
        end else if (wr && PADDR == OFS_CTRL) begin
            wave_mode_sel     <= PWDATA[MODE_LSB +: 3];
            out_action_sel[0] <= PWDATA[ACT_A_LSB +: 2];
            out_action_sel[1] <= PWDATA[ACT_B_LSB +: 2];
        end
    end

    //------------------------------------------------------------
    // Counter unit
    //------------------------------------------------------------
    // Count write beats any tick in the same cycle
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            count_value <= COUNT_RST;
            count_up    <= 1'b1;
        end else if (count_wr) begin
            count_value <= PWDATA[7:0];
        end else if (tick) begin
            case (kind)
                K_CTC: begin
                    count_up    <= 1'b1;
                    // Equality only: a top below the count is missed
                    count_value <= at_top ? COUNT_BOTTOM
                                          : count_value + 8'h01;
                end
                K_FAST: begin
                    count_up    <= 1'b1;
                    count_value <= at_top ? COUNT_BOTTOM
                                          : count_value + 8'h01;
                end
                K_PHASE: begin
                    // Top and bottom each last one tick at the turn
                    if (count_up) begin
                        if (at_top) begin
                            count_up    <= 1'b0;
                            count_value <= count_value - 8'h01;
                        end else begin
                            count_value <= count_value + 8'h01;
                        end
                    end else if (at_bottom) begin
                        count_up    <= 1'b1;
                        count_value <= count_value + 8'h01;
                    end else begin
                        count_value <= count_value - 8'h01;
                    end
                end
                default: begin
                    count_up    <= 1'b1;
                    count_value <= count_value + 8'h01;
                end
            endcase
        end
    end

    // Blocks matches until the next tick, also while stopped
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            block_match <= 1'b0;
        end else if (count_wr) begin
            block_match <= 1'b1;
        end else if (TIMER_TICK) begin
            block_match <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Overflow flag
    //------------------------------------------------------------
    // Overflow event per counting kind
    always_comb begin
        case (kind)
            K_FAST:  ovf_event = tick && at_top;
            K_PHASE: ovf_event = tick && at_bottom && !count_up;
            default: ovf_event = tick && count_value == COUNT_MAX;
        endcase
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            overflow_flag <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag <= 1'b1;
        end else if (flags_wr && PWDATA[FLAG_OVF]) begin
            overflow_flag <= 1'b0;
        end
    end

    // Buffered value moves in at bottom (fast) or top (phase)
    // Fast loads as the count leaves top, the edge of bottom
    assign load = tick && at_top && (kind == K_FAST || (kind == K_PHASE && count_up));

    //------------------------------------------------------------
    // Compare and waveform channels
    //------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_chan
        logic [1:0] act;
        logic [7:0] cmp_ofs;
        logic       can_toggle;
        logic       next_en;

        assign act        = out_action_sel[i];
        assign cmp_ofs    = (i == 0) ? OFS_CMP_A : OFS_CMP_B;
        // Toggle in PWM exists for channel A with bit2 only
        assign can_toggle = (i == 0) && wave_mode_sel[2];
        assign match[i]   = tick && !block_match &&
                            (count_value == compare_value[i]);

        // Compare registers: direct in non-PWM, buffered in PWM
        // Reads return the buffer so software sees its last write
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                compare_buf[i]   <= CMP_RST;
                compare_value[i] <= CMP_RST;
            end else if (wr && PADDR == cmp_ofs) begin
                compare_buf[i] <= PWDATA[7:0];
                if (!pwm) begin
                    compare_value[i] <= PWDATA[7:0];
                end
            end else if (load) begin
                compare_value[i] <= compare_buf[i];
            end
        end

        // Match flag, one tick after the equal count
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                match_flag[i] <= 1'b0;
            end else if (match[i]) begin
                match_flag[i] <= 1'b1;
            end else if (flags_wr && PWDATA[FLAG_MA + i]) begin
                match_flag[i] <= 1'b0;
            end
        end

        // Up-slope match owed at bottom: top left, or start above
        // Dropped outside phase mode so a later switch starts clean
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                pending_up[i] <= 1'b0;
            end else if (kind != K_PHASE) begin
                pending_up[i] <= 1'b0;
            end else if (load && compare_value[i] == top && compare_buf[i] != top) begin
                pending_up[i] <= 1'b1;
            end else if (count_wr && PWDATA[7:0] > compare_value[i]) begin
                pending_up[i] <= 1'b1;
            end else if (tick && at_bottom && !count_up) begin
                pending_up[i] <= 1'b0;
            end
        end

        // Output register; action zero never changes it
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                wave_out[i] <= 1'b0;
            end else if (act == ACT_OFF) begin
                wave_out[i] <= wave_out[i];
            end else if (!pwm) begin
                if (match[i] || (force_wr && PWDATA[i])) begin
                    if (act == ACT_TOGGLE) begin
                        wave_out[i] <= !wave_out[i];
                    end else begin
                        wave_out[i] <= act[0];
                    end
                end
            end else if (act == ACT_TOGGLE) begin
                if (match[i] && can_toggle) begin
                    wave_out[i] <= !wave_out[i];
                end
            end else if (kind == K_FAST) begin
                // Bottom action wins over a match at top
                if (tick && at_top) begin
                    wave_out[i] <= !act[0];
                end else if (match[i]) begin
                    wave_out[i] <= act[0];
                end
            end else begin
                if (tick && at_top && compare_value[i] == top) begin
                    wave_out[i] <= !act[0];
                end else if (match[i] && compare_value[i] != top) begin
                    wave_out[i] <= up_eff ? act[0] : !act[0];
                end else if (tick && at_bottom && !count_up && pending_up[i]) begin
                    wave_out[i] <= act[0];
                end
            end
        end

        // Pin is connected unless the action is off or unsupported
        always_comb begin
            next_en = (act != ACT_OFF);
            if (pwm && act == ACT_TOGGLE && !can_toggle) begin
                next_en = 1'b0;
            end
        end

        // Enable registered so the pin driver comes from a flop
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                wave_en[i] <= 1'b0;
            end else begin
                wave_en[i] <= next_en;
            end
        end
    end

    //------------------------------------------------------------
    // APB read path and handshake
    //------------------------------------------------------------
    // Read mux; unmapped and write-only offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (PADDR)
            OFS_CTRL: begin
                next_rdata[MODE_LSB +: 3]  = wave_mode_sel;
                next_rdata[ACT_A_LSB +: 2] = out_action_sel[0];
                next_rdata[ACT_B_LSB +: 2] = out_action_sel[1];
            end
            OFS_COUNT: next_rdata[7:0] = count_value;
            OFS_CMP_A: next_rdata[7:0] = compare_buf[0];
            OFS_CMP_B: next_rdata[7:0] = compare_buf[1];
            OFS_FLAGS: begin
                next_rdata[FLAG_OVF] = overflow_flag;
                next_rdata[FLAG_MA]  = match_flag[0];
                next_rdata[FLAG_MB]  = match_flag[1];
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Data is captured in the first access cycle, one wait state
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
            if (PSEL && PENABLE && !PREADY && !PWRITE) begin
                PRDATA <= next_rdata;
            end
        end
    end

    //------------------------------------------------------------
    // Outputs, all from flip-flops
    //------------------------------------------------------------
    // Plain wires from the registers, no gating
    assign WAVE_OUT_A    = wave_out[0];
    assign WAVE_OUT_B    = wave_out[1];
    assign WAVE_OUT_A_EN = wave_en[0];
    assign WAVE_OUT_B_EN = wave_en[1];
    assign OVERFLOW_FLAG = overflow_flag;
    assign MATCH_A_FLAG  = match_flag[0];
    assign MATCH_B_FLAG  = match_flag[1];

endmodule

/* File: verification/tb_timer8_waveform_modes.sv */
`timescale 1ns/10ps
module tb_timer8_waveform_modes
    import timer8_pkg::*;
();
    // Design inputs
    logic        clock   = 1'b0;
    logic        rst     = 1'b1;
    logic        tick    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    // Design outputs and load view
    logic [31:0] prdata;
    logic        pready, pslverr, wave_a, wave_a_en, wave_b, wave_b_en, ovf, mat_a, mat_b;
    logic [15:0] rises, period, high_time, base;
    logic        seen;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          tests_run  = 0;
    // Waveform table: control, compare A, period, high time or steady level
    logic [7:0]  m_ctrl [12] = '{8'h23, 8'h33, 8'h23, 8'h23, 8'h17, 8'h53, 8'h12, 8'h21, 8'h21, 8'h21, 8'h31, 8'h15};
    logic [7:0]  m_cmp  [12] = '{8'h80, 8'h80, 8'h00, 8'hFF, 8'h09, 8'h80, 8'h04, 8'h80, 8'h00, 8'hFF, 8'h00, 8'h04};
    logic [15:0] m_per  [12] = '{16'h0100, 16'h0100, 16'h0100, 16'h0000, 16'h0014, 16'h0000,
                                 16'h000A, 16'h01FE, 16'h0000, 16'h0000, 16'h0000, 16'h0010};
    logic [15:0] m_high [12] = '{16'h0081, 16'h007F, 16'h0001, 16'h0001, 16'h000A, 16'h0000,
                                 16'h0005, 16'h0100, 16'h0000, 16'h0001, 16'h0001, 16'h0008};

    always #10 clock = ~clock;

    timer8_waveform_modes uut (
        .CLOCK(clock), .RST(rst), .TIMER_TICK(tick), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .WAVE_OUT_A(wave_a), .WAVE_OUT_A_EN(wave_a_en), .WAVE_OUT_B(wave_b),
        .WAVE_OUT_B_EN(wave_b_en), .OVERFLOW_FLAG(ovf), .MATCH_A_FLAG(mat_a), .MATCH_B_FLAG(mat_b)
    );

    wave_load u_load (
        .clock(clock), .rst(rst), .wave(wave_a), .wave_en(wave_a_en), .rises(rises),
        .period(period), .high_time(high_time), .level(seen)
    );

    //----------------------------------------
    // Bus, tick and compare tasks
    //----------------------------------------
    task automatic wrap_up();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // Request held until ready is sampled, then released
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            wrap_up();
        end
        #1;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    // Exactly n timer ticks, then settle
    task automatic ticks(input int n);
        @(posedge clock);
        tick <= 1'b1;
        repeat (n) @(posedge clock);
        tick <= 1'b0;
        #1;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        $display("[FAIL] run length expected finish seen timeout");
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        // Reset state and unmapped access
        rdchk("ctrl reset", OFS_CTRL, 32'h0000_0000);
        rdchk("count reset", OFS_COUNT, 32'h0000_0000);
        chk("outputs reset", 32'h0000_0000, {25'h0, wave_a, wave_a_en, wave_b, wave_b_en, ovf, mat_a, mat_b});
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        // Normal wrap and overflow
        wr(OFS_CMP_A, 32'h0000_0010);
        wr(OFS_COUNT, 32'h0000_00FE);
        ticks(1);
        rdchk("normal count", OFS_COUNT, 32'h0000_00FF);
        chk("ovf before wrap", 32'h0000_0000, {31'h0, ovf});
        ticks(1);
        rdchk("normal wrap", OFS_COUNT, 32'h0000_0000);
        chk("ovf at zero", 32'h0000_0001, {31'h0, ovf});
        wr(OFS_FLAGS, 32'h0000_0007);
        chk("ovf cleared", 32'h0000_0000, {31'h0, ovf});
        // Count write blocks the next tick's match
        wr(OFS_COUNT, 32'h0000_0010);
        ticks(1);
        chk("match blocked", 32'h0000_0000, {31'h0, mat_a});
        wr(OFS_COUNT, 32'h0000_000F);
        ticks(2);
        chk("match flag", 32'h0000_0001, {31'h0, mat_a});
        // Clear-on-match toggle and missed match
        wr(OFS_FLAGS, 32'h0000_0007);
        wr(OFS_CTRL, 32'h0000_0012);
        wr(OFS_CMP_A, 32'h0000_0003);
        wr(OFS_COUNT, 32'h0000_0000);
        ticks(4);
        rdchk("ctc clear", OFS_COUNT, 32'h0000_0000);
        chk("ctc toggle", 32'h0000_0001, {31'h0, wave_a});
        wr(OFS_COUNT, 32'h0000_0005);
        ticks(251);
        rdchk("ctc wrap", OFS_COUNT, 32'h0000_0000);
        chk("ctc ovf", 32'h0000_0001, {31'h0, ovf});
        chk("ctc no match", 32'h0000_0001, {31'h0, wave_a});
        // Dual slope turn at top and bottom
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_COUNT, 32'h0000_00FE);
        ticks(2);
        rdchk("phase top", OFS_COUNT, 32'h0000_00FE);
        wr(OFS_FLAGS, 32'h0000_0007);
        ticks(254);
        rdchk("phase bottom", OFS_COUNT, 32'h0000_0000);
        chk("ovf early", 32'h0000_0000, {31'h0, ovf});
        ticks(1);
        rdchk("phase up", OFS_COUNT, 32'h0000_0001);
        chk("phase ovf", 32'h0000_0001, {31'h0, ovf});
        // Action off keeps output register under force
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_FORCE, 32'h0000_0003);
        chk("off pin", 32'h0000_0002, {30'h0, wave_a, wave_a_en});
        // Waveform shapes seen by the load, after a settling run
        for (int i = 0; i < 12; i++) begin
            wr(OFS_CTRL, {24'h0, m_ctrl[i]});
            wr(OFS_CMP_A, {24'h0, m_cmp[i]});
            ticks(1100);
            base = rises;
            ticks(1100);
            if (m_per[i] == 16'h0000) begin
                chk("steady rises", 32'h0000_0000, {16'h0, rises - base});
                chk("steady level", {31'h0, m_high[i][0]}, {31'h0, seen});
            end else begin
                chk("period", {16'h0, m_per[i]}, {16'h0, period});
                chk("high time", {16'h0, m_high[i]}, {16'h0, high_time});
            end
        end
        wrap_up();
    end
endmodule

/* File: verification/timer8_waveform_modes_properties.sv */
`timescale 1ns/10ps
module timer8_waveform_modes_checker
    import timer8_pkg::*;
(
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RST,
    // Bench driven
    input wire logic        TIMER_TICK,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    // Design driven
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        WAVE_OUT_A,
    input wire logic        WAVE_OUT_A_EN,
    input wire logic        WAVE_OUT_B_EN,
    input wire logic        OVERFLOW_FLAG,
    input wire logic        MATCH_A_FLAG,
    input wire logic        MATCH_B_FLAG
);
    //----------------------------------------
    // Decoded register writes
    //----------------------------------------
    logic wr_done;
    logic ctrl_wr;
    logic ovf_clr;
    logic force_wr;
    // Only completed transfers count, not setup cycles
    assign wr_done  = PSEL && PENABLE && PREADY && PWRITE;
    assign ctrl_wr  = wr_done && PADDR == OFS_CTRL;
    assign ovf_clr  = wr_done && PADDR == OFS_FLAGS && PWDATA[FLAG_OVF];
    assign force_wr = wr_done && PADDR == OFS_FORCE;

    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    a_ovf_on_tick: assert property ($rose(OVERFLOW_FLAG) |-> $past(TIMER_TICK))
        else $error("overflow flag rose without a tick");
    a_ovf_sticky: assert property ($fell(OVERFLOW_FLAG) |-> $past(ovf_clr))
        else $error("overflow flag fell without a clear");
    a_match_a_tick: assert property ($rose(MATCH_A_FLAG) |-> $past(TIMER_TICK))
        else $error("match A flag rose without a tick");
    a_match_b_tick: assert property ($rose(MATCH_B_FLAG) |-> $past(TIMER_TICK))
        else $error("match B flag rose without a tick");
    a_off_a_disc: assert property (ctrl_wr && PWDATA[5:4] == ACT_OFF |-> ##2 !WAVE_OUT_A_EN)
        else $error("output A still connected with action off");
    a_off_b_disc: assert property (ctrl_wr && PWDATA[7:6] == ACT_OFF |-> ##2 !WAVE_OUT_B_EN)
        else $error("output B still connected with action off");
    a_toggle_a_gate: assert property (ctrl_wr && PWDATA[5:4] == ACT_TOGGLE && PWDATA[0]
        |-> ##2 WAVE_OUT_A_EN == $past(PWDATA[2], 2))
        else $error("output A toggle connection ignores mode bit 2");
    a_no_b_toggle: assert property (ctrl_wr && PWDATA[7:6] == ACT_TOGGLE && PWDATA[0]
        |-> ##2 !WAVE_OUT_B_EN)
        else $error("output B toggle connected in a PWM mode");
    a_wave_a_cause: assert property ($changed(WAVE_OUT_A) |-> $past(TIMER_TICK) || $past(force_wr))
        else $error("output A moved without tick or force");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("slave error without ready");
endmodule

bind timer8_waveform_modes timer8_waveform_modes_checker u_chk (
    .CLOCK(CLOCK), .RST(RST), .TIMER_TICK(TIMER_TICK), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_A_EN(WAVE_OUT_A_EN), .WAVE_OUT_B_EN(WAVE_OUT_B_EN),
    .OVERFLOW_FLAG(OVERFLOW_FLAG), .MATCH_A_FLAG(MATCH_A_FLAG), .MATCH_B_FLAG(MATCH_B_FLAG)
);

/* File: verification/wave_load.sv */
`timescale 1ns/10ps
module wave_load (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Pin from the timer
    input  wire logic        wave,
    input  wire logic        wave_en,
    // Measurements
    output logic      [15:0] rises,
    output logic      [15:0] period,
    output logic      [15:0] high_time,
    output logic             level
);
    logic        prev;
    logic [15:0] since_rise;
    logic [15:0] high_cnt;
    // Released pin sits at the pull-down level
    assign level = wave_en ? wave : 1'b0;
    // Rise-to-rise spacing and width of the last high phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev       <= 1'b0;
            since_rise <= 16'h0000;
            high_cnt   <= 16'h0000;
            rises      <= 16'h0000;
            period     <= 16'h0000;
            high_time  <= 16'h0000;
        end else begin
            prev       <= level;
            since_rise <= since_rise + 16'h0001;
            high_cnt   <= level ? high_cnt + 16'h0001 : 16'h0000;
            if (level && !prev) begin
                rises      <= rises + 16'h0001;
                period     <= since_rise;
                since_rise <= 16'h0001;
            end
            if (!level && prev) begin
                high_time <= high_cnt;
            end
        end
    end
endmodule
